// >>> rtl/rcsf_pkg.sv
// Package with register map, field positions and reset values of the reset cause block
package rcsf_pkg;

  // ****************************************
  // Register bus
  // ****************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  localparam logic [3:0] OFF_CAUSE  = 4'h0;
  localparam logic [3:0] OFF_IRQ_ST = 4'h1;
  localparam logic [3:0] OFF_IRQ_MK = 4'h2;
  localparam logic [3:0] OFF_WDT    = 4'h3;

  // ****************************************
  // Cause register fields
  // ****************************************
  localparam int unsigned BIT_POR   = 0;
  localparam int unsigned BIT_BOR   = 1;
  localparam int unsigned BIT_IDLE  = 2;
  localparam int unsigned BIT_SLEEP = 3;
  localparam int unsigned NFLAGS    = 4;

  // Watchdog control register fields
  localparam int unsigned BIT_WDT_SOFT = 0;
  localparam int unsigned BIT_WDT_RUN  = 1;

  localparam logic [1:0] FUSE_UNPROG = 2'h3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [3:0] RST_MASK  = 4'h0;
  localparam logic       RST_SOFT  = 1'h0;

endpackage : rcsf_pkg

// >>> rtl/rcsf_flag_cell.sv
// One sticky flag bit: hardware set beats software write
module rcsf_flag_cell
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic resetn_in,
  // Controls
  input  wire logic set_in,
  input  wire logic wr_in,
  input  wire logic wr_val_in,
  input  wire logic clr_in,
  // State
  output logic      flag_out
);

  logic flag_reg;
  logic flag_next;

  // Set wins over any clear in the same cycle
  assign flag_next = set_in ? 1'b1 :
                     wr_in  ? wr_val_in :
                     clr_in ? 1'b0 : flag_reg; // [RULE8]

  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next;
  end

  assign flag_out = flag_reg;

endmodule : rcsf_flag_cell

// >>> rtl/rcsf_wdt_gate.sv
// Watchdog enable override from fuse field
module rcsf_wdt_gate
(
  // Inputs
  input  wire logic [1:0] fuse_in,
  input  wire logic       soft_in,
  // Result
  output logic            run_out
);

  // Unprogrammed fuses force the watchdog on
  assign run_out = (fuse_in == rcsf_pkg::FUSE_UNPROG) | soft_in; // [RULE7]

endmodule : rcsf_wdt_gate

// >>> rtl/rcsf_top.sv
// Reset cause and low power status flags with register port and interrupt
//
// Local design decisions: the plain strobed port and the register offsets.

// Behaviour
// [RULE1] The sleep wake flag, bit 3 of the cause register, is set once the device has been in Sleep.
// [RULE2] The idle wake flag, bit 2 of the cause register, is set once the device was in Idle.
// [RULE3] The brownout reset flag, bit 1, is set whenever a brown-out reset occurred.
// [RULE4] The poweron reset flag, bit 0, is set whenever a power-on reset occurred.
// [RULE5] Software may write every status flag to set or clear it.
// [RULE6] A software write setting a flag only stores it and never starts a reset.
// [RULE7] With the watchdog fuse field at 11 the watchdog stays enabled whatever the soft enable.
// [RULE8] Flags stay set until cleared, and a hardware event beats a clear in the same cycle.
module rcsf_top
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  // Hardware events, one-cycle pulses
  input  wire logic        por_event_in,
  input  wire logic        bor_event_in,
  input  wire logic        idle_event_in,
  input  wire logic        sleep_event_in,
  // Watchdog configuration
  input  wire logic [1:0]  watchdog_fuse_enable_in,
  // Register port
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  // Status outputs
  output logic      [3:0]  reset_cause_flags_out,
  output logic             watchdog_timer_enable_out,
  output logic             irq_out
);

  // ****************************************
  // Address decode
  // ****************************************
  // One compare shared by the write strobes and the read mux
  function automatic logic rcsf_hit
  (
    input logic [3:0] addr,
    input logic [3:0] offset
  );
    rcsf_hit = (addr == offset);
  endfunction : rcsf_hit

  logic sel_cause;
  logic sel_ist;
  logic sel_msk;
  logic sel_wdt;

  assign sel_cause = rcsf_hit(addr_in, rcsf_pkg::OFF_CAUSE);
  assign sel_ist   = rcsf_hit(addr_in, rcsf_pkg::OFF_IRQ_ST);
  assign sel_msk   = rcsf_hit(addr_in, rcsf_pkg::OFF_IRQ_MK);
  assign sel_wdt   = rcsf_hit(addr_in, rcsf_pkg::OFF_WDT);

  logic wr_cause;
  logic wr_ist;
  logic wr_msk;
  logic wr_wdt;

  // Unmapped indexes match no strobe, so such writes change nothing
  assign wr_cause = wr_in && sel_cause;
  assign wr_ist   = wr_in && sel_ist;
  assign wr_msk   = wr_in && sel_msk;
  assign wr_wdt   = wr_in && sel_wdt;

  // ****************************************
  // Write data fields
  // ****************************************
  logic [3:0] wd_flags;
  logic       wd_soft;

  assign wd_flags = wdata_in[3:0];
  assign wd_soft  = wdata_in[rcsf_pkg::BIT_WDT_SOFT];

  // ****************************************
  // Hardware events
  // ****************************************
  logic [3:0] hw_evt;

  assign hw_evt[rcsf_pkg::BIT_POR]   = por_event_in;   // [RULE4]
  assign hw_evt[rcsf_pkg::BIT_BOR]   = bor_event_in;   // [RULE3]
  assign hw_evt[rcsf_pkg::BIT_IDLE]  = idle_event_in;  // [RULE2]
  assign hw_evt[rcsf_pkg::BIT_SLEEP] = sleep_event_in; // [RULE1]

  // ****************************************
  // Flags
  // ****************************************
  logic [3:0] cause_flags;
  logic [3:0] irq_flags;
  logic [3:0] ist_clr;

  // Write one to clear: a zero leaves its status bit alone
  assign ist_clr = wr_ist ? wd_flags : 4'h0;

  // Software writes only load the flag; nothing here feeds a reset request
  genvar gi;
  generate
    for (gi = 0; gi < rcsf_pkg::NFLAGS; gi++)
    begin : g_flag
      rcsf_flag_cell u_cause
      (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .set_in     (hw_evt[gi]),
        .wr_in      (wr_cause),
        .wr_val_in  (wd_flags[gi]),
        .clr_in     (1'b0),
        .flag_out   (cause_flags[gi])
      ); // [RULE5] [RULE6]
      rcsf_flag_cell u_irq
      (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .set_in     (hw_evt[gi]),
        .wr_in      (1'b0),
        .wr_val_in  (1'b0),
        .clr_in     (ist_clr[gi]),
        .flag_out   (irq_flags[gi])
      ); // [RULE8]
    end
  endgenerate

  // ****************************************
  // Interrupt
  // ****************************************
  logic [3:0] mask_reg;
  logic [3:0] mask_next;
  logic [3:0] irq_pend;
  logic       irq_next;

  always_comb
  begin
    if (wr_msk)
    begin
      mask_next = wd_flags;
    end
    else
    begin
      mask_next = mask_reg;
    end
  end

  generate
    for (gi = 0; gi < rcsf_pkg::NFLAGS; gi++)
    begin : g_pend
      assign irq_pend[gi] = irq_flags[gi] && mask_reg[gi];
    end
  endgenerate

  // Level output: it falls only when software clears the status or the mask
  assign irq_next = |irq_pend;

  // ****************************************
  // Watchdog
  // ****************************************
  logic soft_reg;
  logic soft_next;
  logic wdt_run;

  always_comb
  begin
    if (wr_wdt)
    begin
      soft_next = wd_soft;
    end
    else
    begin
      soft_next = soft_reg;
    end
  end

  rcsf_wdt_gate u_wdt
  (
    .fuse_in (watchdog_fuse_enable_in),
    .soft_in (soft_reg),
    .run_out (wdt_run)
  ); // [RULE7]

  // ****************************************
  // Readback
  // ****************************************
  // Zero extension of a four bit field, shared by every register word
  function automatic logic [15:0] rcsf_word
  (
    input logic [3:0] field
  );
    rcsf_word = {12'h000, field};
  endfunction : rcsf_word

  logic [15:0] rd_cause_word;
  logic [15:0] rd_ist_word;
  logic [15:0] rd_msk_word;
  logic [15:0] rd_wdt_word;
  logic [15:0] rd_mux;
  logic [15:0] rdata_next;

  assign rd_cause_word = rcsf_word(cause_flags);
  assign rd_ist_word   = rcsf_word(irq_flags);
  assign rd_msk_word   = rcsf_word(mask_reg);
  assign rd_wdt_word   = rcsf_word({2'h0, wdt_run, soft_reg});

  // Unmapped indexes and unused bits read as zero
  always_comb
  begin
    if (sel_cause)
    begin
      rd_mux = rd_cause_word;
    end
    else if (sel_ist)
    begin
      rd_mux = rd_ist_word;
    end
    else if (sel_msk)
    begin
      rd_mux = rd_msk_word;
    end
    else if (sel_wdt)
    begin
      rd_mux = rd_wdt_word;
    end
    else
    begin
      rd_mux = 16'h0000;
    end
  end

  // Data stand one cycle only, so an idle bus never shows a stale word
  always_comb
  begin
    if (rd_in)
    begin
      rdata_next = rd_mux;
    end
    else
    begin
      rdata_next = 16'h0000;
    end
  end

  // ****************************************
  // Output values
  // ****************************************
  logic [3:0] flags_next;
  logic       wdt_next;

  // Every output is a flop, one cycle behind the state it mirrors
  assign flags_next = cause_flags;
  assign wdt_next   = wdt_run;

  // ****************************************
  // Register: interrupt mask
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      mask_reg <= rcsf_pkg::RST_MASK;
    end
    else
    begin
      mask_reg <= mask_next;
    end
  end

  // ****************************************
  // Register: watchdog soft enable
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      soft_reg <= rcsf_pkg::RST_SOFT;
    end
    else
    begin
      soft_reg <= soft_next;
    end
  end

  // ****************************************
  // Register: read data
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      rdata_out <= 16'h0000;
    end
    else
    begin
      rdata_out <= rdata_next;
    end
  end

  // ****************************************
  // Register: cause flag copy
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      reset_cause_flags_out <= rcsf_pkg::RST_FLAGS;
    end
    else
    begin
      reset_cause_flags_out <= flags_next;
    end
  end

  // ****************************************
  // Register: watchdog enable
  // ****************************************
  // Fuses are read every cycle, so a fuse change shows up one cycle later
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      watchdog_timer_enable_out <= 1'b0;
    end
    else
    begin
      watchdog_timer_enable_out <= wdt_next; // [RULE7]
    end
  end

  // ****************************************
  // Register: interrupt line
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= irq_next;
    end
  end

endmodule : rcsf_top

// >>> testbench/rcsf_props.sv
// Checker of the reset cause block ports
module rcsf_props
(
  // Clock, reset and events
  input wire logic        ref_clk_in,
  input wire logic        resetn_in,
  input wire logic        por_event_in,
  input wire logic        bor_event_in,
  input wire logic        idle_event_in,
  input wire logic        sleep_event_in,
  input wire logic [1:0]  watchdog_fuse_enable_in,
  // Register port
  input wire logic [3:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  // Status
  input wire logic [3:0]  reset_cause_flags_out,
  input wire logic        watchdog_timer_enable_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // Events force a flag even against a write, so writes are judged only when quiet
  wire logic ev_any = por_event_in | bor_event_in | idle_event_in | sleep_event_in;
  wire logic wr_cause = wr_in && addr_in == 4'h0;
  sleep_set_a: assert property (sleep_event_in |-> ##2 reset_cause_flags_out[3]) else $error("sleep flag");
  idle_set_a: assert property (idle_event_in |-> ##2 reset_cause_flags_out[2]) else $error("idle flag");
  bor_set_a: assert property (bor_event_in |-> ##2 reset_cause_flags_out[1]) else $error("bor flag");
  por_set_a: assert property (por_event_in |-> ##2 reset_cause_flags_out[0]) else $error("por flag");
  cause_write_a: assert property ((wr_cause && !ev_any) ##1 !ev_any |-> ##1
    reset_cause_flags_out == $past(wdata_in[3:0], 2)) else $error("cause write");
  soft_set_a: assert property ((wr_cause && wdata_in[3:0] == 4'hf) ##1 !wr_in [*3] |->
    reset_cause_flags_out == 4'hf) else $error("soft set lost");
  fuse_force_a: assert property (watchdog_fuse_enable_in == 2'h3 |=> watchdog_timer_enable_out)
    else $error("fuse force");
  flag_hold_a: assert property (reset_cause_flags_out[1] && !$past(wr_cause) |=> reset_cause_flags_out[1])
    else $error("flag hold");
  read_idle_a: assert property (!rd_in |=> rdata_out == 16'h0000) else $error("read data stale");
  cover property (sleep_event_in);
  cover property (irq_out);
  cover property (wr_in && addr_in == 4'h3);
endmodule : rcsf_props

bind rcsf_top rcsf_props u_props (.ref_clk_in, .resetn_in, .por_event_in, .bor_event_in, .idle_event_in,
  .sleep_event_in, .watchdog_fuse_enable_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .reset_cause_flags_out, .watchdog_timer_enable_out, .irq_out);

// >>> testbench/reset_cause_status_flags_bench.sv
// Bench of the reset cause block
module reset_cause_status_flags_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0;
  logic [3:0] ev = 0, addr_in = 0;
  logic [1:0] fuse = 0;
  logic [15:0] wdata_in = 0;
  wire logic [15:0] rdata_out;
  wire logic [3:0] flags;
  wire logic wdt, irq;
  int err_count = 0, n_checks = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  rcsf_top dut (.ref_clk_in, .resetn_in, .por_event_in(ev[0]), .bor_event_in(ev[1]), .idle_event_in(ev[2]),
    .sleep_event_in(ev[3]), .watchdog_fuse_enable_in(fuse), .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .reset_cause_flags_out(flags), .watchdog_timer_enable_out(wdt), .irq_out(irq));
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
      err_count++;
    end
  endtask : chk
  // Events ride along with the write so a clash with a clear can be staged
  task wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] e);
    @(posedge ref_clk_in) {addr_in, wdata_in, wr_in, ev} <= {a, d, 1'b1, e};
    @(posedge ref_clk_in) {wr_in, ev} <= 5'h00;
  endtask : wr
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk_in) {addr_in, rd_in} <= {a, 1'b1};
    @(posedge ref_clk_in) rd_in <= 1'b0;
    #1 chk(rdata_out, e);
    @(posedge ref_clk_in) #1 chk(rdata_out, 16'h0000);
  endtask : rd
  initial
  begin
    #100000;
    err_count++;
    end_of_test;
  end
  initial
  begin
    repeat (5) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 4; i++) rd(i, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      wr(4'hf, 16'h0000, 4'h1 << i);
      rd(4'h0, 16'h0001 << i);
      wr(4'h0, 16'h0000, 4'h0);
    end
    rd(4'h1, 16'h000f);
    chk(irq, 16'h0000);
    wr(4'h0, 16'h000a, 4'h0);
    rd(4'h0, 16'h000a);
    wr(4'h0, 16'h000f, 4'h0);
    rd(4'h9, 16'h0000);
    rd(4'h0, 16'h000f);
    wr(4'h0, 16'h0000, 4'h2);
    rd(4'h0, 16'h0002);
    wr(4'h2, 16'h0004, 4'h0);
    rd(4'h2, 16'h0004);
    chk(irq, 16'h0001);
    wr(4'h1, 16'h0004, 4'h0);
    rd(4'h1, 16'h000b);
    chk(irq, 16'h0000);
    wr(4'h1, 16'h0001, 4'h1);
    rd(4'h1, 16'h000b);
    @(posedge ref_clk_in) fuse <= 2'h3;
    rd(4'h3, 16'h0002);
    chk(wdt, 16'h0001);
    @(posedge ref_clk_in) fuse <= 2'h0;
    wr(4'h3, 16'h0001, 4'h0);
    rd(4'h3, 16'h0003);
    wr(4'h3, 16'h0000, 4'h0);
    rd(4'h3, 16'h0000);
    chk(wdt, 16'h0000);
    end_of_test;
  end
endmodule : reset_cause_status_flags_bench
